// ---- hdl/msp_pkg.sv ----
// constants and types for the serial port setup block
// Summary of operation
// R1: port idle at 0, running at 1
// R2: role code picks master or slave kind
// R3: float flag one marks real-value accesses
// R4: register at or above start is float
// R5: float requests rebased at float base
// R6: framing zero RTU, one ASCII
// R7: baud given as literal numeric value
// R8: generate and check none, odd, even parity
// R9: five to eight data bits
// R10: one or two stop bits sent
// R11: lead delay after RTS before data
// R12: lag delay after last byte, RTS low
// R13: minimum reply delay before lead delay
// R14: CTS gate holds transmit until high
// R15: process requests carrying own address
// R16: drop other addresses without reply
package msp_pkg;
   localparam logic [15:0] OFS_PORT_ENABLE = 16'h13B0;
   localparam logic [15:0] OFS_PORT_ROLE = 16'h13B1;
   localparam logic [15:0] OFS_REAL_ENABLE = 16'h13B2;
   localparam logic [15:0] OFS_REAL_FIRST = 16'h13B3;
   localparam logic [15:0] OFS_REAL_BASE = 16'h13B4;
   localparam logic [15:0] OFS_FRAMING = 16'h13B5;
   localparam logic [15:0] OFS_LINE_SPEED = 16'h13B6;
   localparam logic [15:0] OFS_PARITY = 16'h13B7;
   localparam logic [15:0] OFS_CHAR_LEN = 16'h13B8;
   localparam logic [15:0] OFS_STOP_LEN = 16'h13B9;
   localparam logic [15:0] OFS_LEAD = 16'h13BA;
   localparam logic [15:0] OFS_LAG = 16'h13BB;
   localparam logic [15:0] OFS_REPLY_MIN = 16'h13BC;
   localparam logic [15:0] OFS_CTS_GATE = 16'h13BD;
   localparam logic [15:0] OFS_NODE_ADDR = 16'h13BE;
   localparam int NUM_REGS = 15;
   // reset values: port disabled, slave, 8N1 at 9600, address 1
   localparam logic [15:0] RST_ROLE = 16'h0001;
   localparam logic [15:0] RST_SPEED = 16'h2580;
   localparam logic [15:0] RST_CHAR_LEN = 16'h0008;
   localparam logic [15:0] RST_STOP_LEN = 16'h0001;
   localparam logic [15:0] RST_NODE_ADDR = 16'h0001;
   // parity codes
   localparam logic [15:0] PAR_NONE = 16'h0000;
   localparam logic [15:0] PAR_ODD = 16'h0001;
   localparam logic [15:0] PAR_EVEN = 16'h0002;
   // role codes
   localparam logic [15:0] ROLE_MASTER = 16'h0000;
   localparam logic [15:0] ROLE_SLAVE = 16'h0001;
   localparam logic [15:0] ROLE_PASS_RAW = 16'h0002;
   localparam logic [15:0] ROLE_PASS_SWAP = 16'h0003;
   // the code 115 stands for 115200 baud
   localparam logic [15:0] SPEED_TOP_CODE = 16'h0073;
   localparam int CLK_HZ = 25_000_000;
   localparam int MS_TIME = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
   localparam int DIV_W = 20;
   typedef struct packed {
      logic [15:0] enable;
      logic [15:0] role;
      logic [15:0] real_en;
      logic [15:0] real_first;
      logic [15:0] real_base;
      logic [15:0] framing;
      logic [15:0] speed;
      logic [15:0] parity;
      logic [15:0] char_len;
      logic [15:0] stop_len;
      logic [15:0] lead;
      logic [15:0] lag;
      logic [15:0] reply_min;
      logic [15:0] cts_gate;
      logic [15:0] node_addr;
   } msp_cfg_s;
   typedef struct packed {
      logic is_real;
      logic [15:0] db_reg;
   } msp_map_s;
   typedef enum logic [2:0] {ST_IDLE, ST_REPLY, ST_LEAD, ST_SEND, ST_LAG} msp_seq_e;
   typedef enum logic [1:0] {TX_IDLE, TX_BITS, TX_STOP} msp_tx_e;
endpackage

// ---- hdl/msp_port.sv ----
// second serial port: setup registers, transmit sequencing, receive filter
`timescale 1ns/100ps
`default_nettype none
module msp_port (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // configuration word port
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [15:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   output logic [15:0] cfg_rdata,
   output logic cfg_rvalid,
   // register access classification
   input wire logic acc_valid,
   input wire logic [7:0] acc_func,
   input wire logic [15:0] acc_reg,
   input wire logic [15:0] acc_hold_base,
   output msp_pkg::msp_map_s acc_map,
   output logic acc_map_valid,
   // outgoing message bytes
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_last,
   output logic tx_ready,
   // received request header
   input wire logic rx_hdr_valid,
   input wire logic [7:0] rx_hdr_addr,
   output logic req_accept,
   output logic req_drop,
   // received characters for parity check
   input wire logic rx_char_valid,
   input wire logic [8:0] rx_char,
   output logic rx_parity_err,
   // serial line and modem control
   input wire logic baud_tick,
   input wire logic cts,
   output logic txd,
   output logic rts,
   // status
   output logic port_active,
   output logic [1:0] role,
   output logic ascii_mode
);
   msp_pkg::msp_cfg_s cfg, next_cfg;
   logic [15:0] next_cfg_rdata;
   logic next_cfg_rvalid;
   // config write decode, readback
   always_comb begin
      next_cfg = cfg;
      next_cfg_rdata = cfg_rdata;
      next_cfg_rvalid = cfg_rd;
      if (cfg_wr) begin
         case (cfg_addr)
            msp_pkg::OFS_PORT_ENABLE: next_cfg.enable = cfg_wdata;
            msp_pkg::OFS_PORT_ROLE: next_cfg.role = cfg_wdata;
            msp_pkg::OFS_REAL_ENABLE: next_cfg.real_en = cfg_wdata;
            msp_pkg::OFS_REAL_FIRST: next_cfg.real_first = cfg_wdata;
            msp_pkg::OFS_REAL_BASE: next_cfg.real_base = cfg_wdata;
            msp_pkg::OFS_FRAMING: next_cfg.framing = cfg_wdata;
            // R7: speed kept as literal value
            msp_pkg::OFS_LINE_SPEED: next_cfg.speed = cfg_wdata;
            msp_pkg::OFS_PARITY: next_cfg.parity = cfg_wdata;
            msp_pkg::OFS_CHAR_LEN: next_cfg.char_len = cfg_wdata;
            msp_pkg::OFS_STOP_LEN: next_cfg.stop_len = cfg_wdata;
            msp_pkg::OFS_LEAD: next_cfg.lead = cfg_wdata;
            msp_pkg::OFS_LAG: next_cfg.lag = cfg_wdata;
            msp_pkg::OFS_REPLY_MIN: next_cfg.reply_min = cfg_wdata;
            msp_pkg::OFS_CTS_GATE: next_cfg.cts_gate = cfg_wdata;
            msp_pkg::OFS_NODE_ADDR: next_cfg.node_addr = cfg_wdata;
            default: ;
         endcase
      end
      if (cfg_rd) begin
         case (cfg_addr)
            msp_pkg::OFS_PORT_ENABLE: next_cfg_rdata = cfg.enable;
            msp_pkg::OFS_PORT_ROLE: next_cfg_rdata = cfg.role;
            msp_pkg::OFS_REAL_ENABLE: next_cfg_rdata = cfg.real_en;
            msp_pkg::OFS_REAL_FIRST: next_cfg_rdata = cfg.real_first;
            msp_pkg::OFS_REAL_BASE: next_cfg_rdata = cfg.real_base;
            msp_pkg::OFS_FRAMING: next_cfg_rdata = cfg.framing;
            msp_pkg::OFS_LINE_SPEED: next_cfg_rdata = cfg.speed;
            msp_pkg::OFS_PARITY: next_cfg_rdata = cfg.parity;
            msp_pkg::OFS_CHAR_LEN: next_cfg_rdata = cfg.char_len;
            msp_pkg::OFS_STOP_LEN: next_cfg_rdata = cfg.stop_len;
            msp_pkg::OFS_LEAD: next_cfg_rdata = cfg.lead;
            msp_pkg::OFS_LAG: next_cfg_rdata = cfg.lag;
            msp_pkg::OFS_REPLY_MIN: next_cfg_rdata = cfg.reply_min;
            msp_pkg::OFS_CTS_GATE: next_cfg_rdata = cfg.cts_gate;
            msp_pkg::OFS_NODE_ADDR: next_cfg_rdata = cfg.node_addr;
            default: next_cfg_rdata = 16'h0000;
         endcase
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         cfg <= '{enable: 16'h0000, role: msp_pkg::RST_ROLE, real_en: 16'h0000,
                  real_first: 16'h0000, real_base: 16'h0000, framing: 16'h0000,
                  speed: msp_pkg::RST_SPEED, parity: msp_pkg::PAR_NONE,
                  char_len: msp_pkg::RST_CHAR_LEN, stop_len: msp_pkg::RST_STOP_LEN,
                  lead: 16'h0000, lag: 16'h0000, reply_min: 16'h0000,
                  cts_gate: 16'h0000, node_addr: msp_pkg::RST_NODE_ADDR};
         cfg_rdata <= 16'h0000;
         cfg_rvalid <= 1'b0;
      end else begin
         cfg <= next_cfg;
         cfg_rdata <= next_cfg_rdata;
         cfg_rvalid <= next_cfg_rvalid;
      end
   end

   logic enabled;
   logic slave_role;
   // R1: enable word exact
   assign enabled = (cfg.enable == 16'h0001);
   // R2: role code decode
   assign slave_role = (cfg.role == msp_pkg::ROLE_SLAVE) ||
                       (cfg.role == msp_pkg::ROLE_PASS_RAW) ||
                       (cfg.role == msp_pkg::ROLE_PASS_SWAP);

   // register access mapping
   msp_pkg::msp_map_s next_acc_map;
   logic next_acc_map_valid;
   logic holding_func;
   assign holding_func = (acc_func == 8'h03) || (acc_func == 8'h06) || (acc_func == 8'h10);
   always_comb begin
      next_acc_map_valid = acc_valid;
      next_acc_map.is_real = 1'b0;
      next_acc_map.db_reg = acc_reg + acc_hold_base;
      // R3: float only on 3, 6, 16
      // R4: at or above first register
      if (cfg.real_en == 16'h0001 && holding_func && acc_reg >= cfg.real_first) begin
         next_acc_map.is_real = 1'b1;
         // R5: rebase onto float base
         next_acc_map.db_reg = cfg.real_base + (acc_reg - cfg.real_first);
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         acc_map <= '0;
         acc_map_valid <= 1'b0;
      end else begin
         acc_map <= next_acc_map;
         acc_map_valid <= next_acc_map_valid;
      end
   end

   // receive address filter and parity check
   logic next_req_accept, next_req_drop, next_rx_parity_err;
   logic rx_par;
   always_comb begin
      next_req_accept = 1'b0;
      next_req_drop = 1'b0;
      // R15: own address accepted
      // R16: others dropped, no reply
      if (rx_hdr_valid && enabled && slave_role) begin
         next_req_accept = ({8'h00, rx_hdr_addr} == cfg.node_addr);
         next_req_drop = !next_req_accept;
      end
      rx_par = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(cfg.char_len[3:0])) rx_par = rx_par ^ rx_char[i];
      end
      // R8: received parity check
      next_rx_parity_err = rx_char_valid && enabled && (cfg.parity != msp_pkg::PAR_NONE) &&
         ((rx_par ^ rx_char[cfg.char_len[3:0]]) != (cfg.parity == msp_pkg::PAR_ODD));
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         req_accept <= 1'b0;
         req_drop <= 1'b0;
         rx_parity_err <= 1'b0;
      end else begin
         req_accept <= next_req_accept;
         req_drop <= next_req_drop;
         rx_parity_err <= next_rx_parity_err;
      end
   end

   // two-entry buffer in the byte path; a stalled line never loses a byte
   logic [8:0] buf_q [2];
   logic [1:0] buf_cnt, next_buf_cnt;
   logic buf_rd_ptr, buf_wr_ptr, next_buf_rd_ptr, next_buf_wr_ptr;
   logic [8:0] next_buf0, next_buf1;
   logic buf_push, buf_pop, next_tx_ready;
   assign buf_push = tx_valid && tx_ready;
   always_comb begin
      next_buf0 = buf_q[0];
      next_buf1 = buf_q[1];
      next_buf_wr_ptr = buf_wr_ptr ^ buf_push;
      next_buf_rd_ptr = buf_rd_ptr ^ buf_pop;
      if (buf_push && !buf_wr_ptr) next_buf0 = {tx_last, tx_data};
      if (buf_push && buf_wr_ptr) next_buf1 = {tx_last, tx_data};
      next_buf_cnt = buf_cnt + {1'b0, buf_push} - {1'b0, buf_pop};
      // ready is registered, so it looks one word ahead
      next_tx_ready = enabled && (next_buf_cnt == 2'd0 ||
                      (next_buf_cnt == 2'd1 && !buf_push));
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         buf_q[0] <= 9'h000;
         buf_q[1] <= 9'h000;
         buf_cnt <= 2'd0;
         buf_rd_ptr <= 1'b0;
         buf_wr_ptr <= 1'b0;
         tx_ready <= 1'b0;
      end else begin
         buf_q[0] <= next_buf0;
         buf_q[1] <= next_buf1;
         buf_cnt <= next_buf_cnt;
         buf_rd_ptr <= next_buf_rd_ptr;
         buf_wr_ptr <= next_buf_wr_ptr;
         tx_ready <= next_tx_ready;
      end
   end

   // millisecond sequencer and character shifter
   localparam int DIV_W = msp_pkg::DIV_W;
   msp_pkg::msp_seq_e seq, next_seq;
   msp_pkg::msp_tx_e txs, next_txs;
   logic [DIV_W-1:0] ms_div, next_ms_div;
   logic [15:0] ms_cnt, next_ms_cnt;
   logic [10:0] shreg, next_shreg;
   logic [3:0] bits_left, next_bits_left;
   logic next_txd, next_rts, char_last, next_char_last, ms_tick, par_bit;
   assign ms_tick = (ms_div == DIV_W'(msp_pkg::MS_CYCLES - 1));
   always_comb begin
      next_seq = seq;
      next_txs = txs;
      next_ms_div = ms_tick ? '0 : ms_div + 1'b1;
      next_ms_cnt = ms_cnt;
      next_shreg = shreg;
      next_bits_left = bits_left;
      next_char_last = char_last;
      next_txd = txd;
      next_rts = rts;
      buf_pop = 1'b0;
      par_bit = ^(buf_q[buf_rd_ptr][7:0] & (8'hFF >> (4'd8 - cfg.char_len[3:0])));
      if (cfg.parity == msp_pkg::PAR_ODD) par_bit = !par_bit;
      case (seq)
         msp_pkg::ST_IDLE: begin
            next_rts = 1'b0;
            next_txd = 1'b1;
            if (enabled && buf_cnt != 2'd0) begin
               next_seq = msp_pkg::ST_REPLY;
               next_ms_cnt = 16'h0000;
               next_ms_div = '0;
            end
         end
         // R13: reply delay precedes RTS lead
         msp_pkg::ST_REPLY: begin
            if (ms_cnt >= cfg.reply_min) begin
               next_seq = msp_pkg::ST_LEAD;
               next_rts = 1'b1;
               next_ms_cnt = 16'h0000;
               next_ms_div = '0;
            end else if (ms_tick) next_ms_cnt = ms_cnt + 16'h0001;
         end
         // R11: lead delay after RTS
         msp_pkg::ST_LEAD: begin
            if (ms_cnt >= cfg.lead) next_seq = msp_pkg::ST_SEND;
            else if (ms_tick) next_ms_cnt = ms_cnt + 16'h0001;
         end
         msp_pkg::ST_SEND: begin
            case (txs)
               msp_pkg::TX_IDLE: begin
                  // R14: CTS gate
                  if (buf_cnt != 2'd0 && (cfg.cts_gate != 16'h0001 || cts) && baud_tick) begin
                     buf_pop = 1'b1;
                     next_char_last = buf_q[buf_rd_ptr][8];
                     // R8: parity above data
                     // short characters keep their low bits; ones fill above
                     next_shreg = {3'b111, buf_q[buf_rd_ptr][7:0]};
                     next_shreg = next_shreg | (11'h7FF << (cfg.char_len[3:0] +
                                  (cfg.parity != msp_pkg::PAR_NONE)));
                     if (cfg.parity != msp_pkg::PAR_NONE) begin
                        next_shreg[cfg.char_len[3:0]] = par_bit;
                     end
                     // R9: data length sets count
                     next_bits_left = cfg.char_len[3:0] +
                                      {3'b000, cfg.parity != msp_pkg::PAR_NONE};
                     next_txd = 1'b0;
                     next_txs = msp_pkg::TX_BITS;
                  end
               end
               msp_pkg::TX_BITS: begin
                  if (baud_tick) begin
                     next_txd = shreg[0];
                     next_shreg = {1'b1, shreg[10:1]};
                     next_bits_left = bits_left - 4'd1;
                     if (bits_left == 4'd1) begin
                        // R10: one or two stops
                        next_bits_left = (cfg.stop_len == 16'h0002) ? 4'd2 : 4'd1;
                        next_txs = msp_pkg::TX_STOP;
                     end
                  end
               end
               msp_pkg::TX_STOP: begin
                  if (baud_tick) begin
                     next_txd = 1'b1;
                     next_bits_left = bits_left - 4'd1;
                     if (bits_left == 4'd0 || bits_left == 4'd1) begin
                        next_txs = msp_pkg::TX_IDLE;
                        if (char_last) begin
                           next_seq = msp_pkg::ST_LAG;
                           next_ms_cnt = 16'h0000;
                           next_ms_div = '0;
                        end
                     end
                  end
               end
               default: next_txs = msp_pkg::TX_IDLE;
            endcase
         end
         // R12: lag before RTS drop
         msp_pkg::ST_LAG: begin
            if (ms_cnt >= cfg.lag) begin
               next_rts = 1'b0;
               next_seq = msp_pkg::ST_IDLE;
            end else if (ms_tick) next_ms_cnt = ms_cnt + 16'h0001;
         end
         default: next_seq = msp_pkg::ST_IDLE;
      endcase
      // R1: disabling idles the port
      if (!enabled) begin
         next_seq = msp_pkg::ST_IDLE;
         next_txs = msp_pkg::TX_IDLE;
         next_rts = 1'b0;
         next_txd = 1'b1;
      end
   end
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         seq <= msp_pkg::ST_IDLE;
         txs <= msp_pkg::TX_IDLE;
         ms_div <= '0;
         ms_cnt <= 16'h0000;
         shreg <= 11'h7FF;
         bits_left <= 4'd0;
         char_last <= 1'b0;
         txd <= 1'b1;
         rts <= 1'b0;
         port_active <= 1'b0;
         role <= 2'd1;
         ascii_mode <= 1'b0;
      end else begin
         seq <= next_seq;
         txs <= next_txs;
         ms_div <= next_ms_div;
         ms_cnt <= next_ms_cnt;
         shreg <= next_shreg;
         bits_left <= next_bits_left;
         char_last <= next_char_last;
         txd <= next_txd;
         rts <= next_rts;
         port_active <= enabled;
         role <= cfg.role[1:0];
         // R6: framing select
         ascii_mode <= (cfg.framing == 16'h0001);
      end
   end

   // R14: no start bit while gated
   a_cts_gate: assert property (@(posedge ref_clk) disable iff (reset)
      (txs == msp_pkg::TX_IDLE && cfg.cts_gate == 16'h0001 && !cts) |=> txd) // R14
      else $error("start bit sent with cts low");
   // R16: drop never replies
   a_addr_filter: assert property (@(posedge ref_clk) disable iff (reset)
      !(req_accept && req_drop)) // R16
      else $error("request both accepted and dropped");
   // R1: disabled port is quiet
   a_port_off: assert property (@(posedge ref_clk) disable iff (reset)
      !enabled |=> !rts ##1 !rts) // R1
      else $error("rts while port disabled");
   // R11: data only after rts
   a_lead_first: assert property (@(posedge ref_clk) disable iff (reset)
      $fell(txd) |-> rts) // R11
      else $error("start bit without rts");
   // R12: while enabled, rts drops only from lag
   a_lag_end: assert property (@(posedge ref_clk) disable iff (reset)
      ($fell(rts) && $past(enabled)) |-> $past(seq) == msp_pkg::ST_LAG) // R12
      else $error("rts dropped outside lag");
   // R13: rts rises after reply wait
   a_reply_wait: assert property (@(posedge ref_clk) disable iff (reset)
      $rose(rts) |-> $past(seq) == msp_pkg::ST_REPLY) // R13
      else $error("rts raised without reply wait");
   // R15: matching address accepted
   a_addr_match: assert property (@(posedge ref_clk) disable iff (reset)
      (rx_hdr_valid && enabled && slave_role && {8'h00, rx_hdr_addr} == cfg.node_addr)
      |=> req_accept) // R15
      else $error("own address not accepted");
   // R4: below start never float
   a_real_class: assert property (@(posedge ref_clk) disable iff (reset)
      (acc_valid && acc_reg < cfg.real_first) |=> !acc_map.is_real) // R4
      else $error("low register classed float");
endmodule // msp_port
`default_nettype wire

// ---- bench/msp_remote.sv ----
// remote serial node: answers rts with cts and decodes characters off txd
`timescale 1ns/100ps
`default_nettype none
module msp_remote (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset,
   // serial line
   input wire logic baud_tick,
   input wire logic txd,
   input wire logic rts,
   output logic cts,
   // bench side
   input wire logic cts_hold,
   input wire logic [3:0] nbits,
   output logic [8:0] got_char,
   output logic got_valid,
   output logic [3:0] last_gap
);
   logic busy;
   logic [3:0] cnt, gap;
   logic [8:0] sh;
   // half-duplex modem: cts follows rts unless the bench holds it off
   assign cts = rts & ~cts_hold;
   // one sample per bit time; gap counts high samples between two characters
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         busy <= 1'b0;
         cnt <= 4'h0;
         gap <= 4'h0;
         sh <= 9'h0;
         got_char <= 9'h0;
         got_valid <= 1'b0;
         last_gap <= 4'h0;
      end else begin
         got_valid <= 1'b0;
         if (baud_tick && !busy && txd == 1'b0) begin
            busy <= 1'b1;
            cnt <= 4'h0;
            last_gap <= gap;
         end else if (baud_tick && !busy && gap != 4'hF) begin
            gap <= gap + 4'h1;
         end else if (baud_tick && busy) begin
            sh <= {txd, sh[8:1]};
            cnt <= cnt + 4'h1;
            if (cnt == nbits - 4'h1) begin
               busy <= 1'b0;
               gap <= 4'h0;
               got_valid <= 1'b1;
               got_char <= {txd, sh[8:1]} >> (4'h9 - nbits);
            end
         end
      end
   end
endmodule // msp_remote
`default_nettype wire

// ---- bench/msp_port_tb.sv ----
// self-checking bench for the serial port setup block
`timescale 1ns/100ps
`default_nettype none
module msp_port_tb;
   typedef struct packed {
      logic [2:0] op;
      logic [7:0] a;
      logic [15:0] b;
      logic [16:0] e;
   } msp_row_s;
   localparam logic [2:0] RD = 3'h0, WR = 3'h1, ACC = 3'h2, HDR = 3'h3, RXC = 3'h4, STS = 3'h5;
   logic ref_clk = 1'b0, reset = 1'b1;
   logic cfg_wr = 1'b0, cfg_rd = 1'b0, acc_valid = 1'b0, tx_valid = 1'b0, tx_last = 1'b0;
   logic rx_hdr_valid = 1'b0, rx_char_valid = 1'b0, baud_tick = 1'b0, cts_hold = 1'b0;
   logic [15:0] cfg_addr = 16'h0, cfg_wdata = 16'h0, acc_reg = 16'h0, acc_hold_base = 16'h32;
   logic [7:0] acc_func = 8'h0, tx_data = 8'h0, rx_hdr_addr = 8'h0;
   logic [8:0] rx_char = 9'h0, got_char;
   logic [3:0] nbits = 4'h9, last_gap;
   logic [1:0] role, tick_cnt = 2'h0;
   logic [15:0] cfg_rdata;
   msp_pkg::msp_map_s acc_map;
   logic cfg_rvalid, acc_map_valid, tx_ready, req_accept, req_drop, rx_parity_err;
   logic txd, rts, cts, port_active, ascii_mode, got_valid;
   int err_total = 0, n_compared = 0, cyc = 0;
   const msp_row_s rows [50] = '{
      '{RD,8'hB0,'0,17'h0}, '{RD,8'hB1,'0,17'h1}, '{RD,8'hB6,'0,17'h2580},
      '{RD,8'hB8,'0,17'h8}, '{RD,8'hB9,'0,17'h1}, '{RD,8'hBE,'0,17'h1},
      '{RD,8'hBF,'0,17'h0}, '{HDR,8'h01,'0,17'h0}, '{STS,8'h0,'0,17'h2},
      '{WR,8'hB0,16'h1,'0}, '{STS,8'h0,'0,17'hA}, '{HDR,8'h01,'0,17'h2},
      '{HDR,8'h02,'0,17'h1}, '{WR,8'hBE,16'hFF,'0}, '{HDR,8'hFF,'0,17'h2},
      '{WR,8'hB1,16'h0,'0}, '{STS,8'h0,'0,17'h8}, '{HDR,8'hFF,'0,17'h0},
      '{WR,8'hB1,16'h3,'0}, '{STS,8'h0,'0,17'hE}, '{HDR,8'hFF,'0,17'h2},
      '{WR,8'hB1,16'h2,'0}, '{HDR,8'hFF,'0,17'h2}, '{WR,8'hB5,16'h1,'0},
      '{STS,8'h0,'0,17'hD}, '{WR,8'hB5,16'h0,'0}, '{WR,8'hB6,16'h73,'0},
      '{RD,8'hB6,'0,17'h73}, '{ACC,8'h03,16'h105,17'h137}, '{WR,8'hB3,16'h100,'0},
      '{WR,8'hB4,16'h800,'0}, '{WR,8'hB2,16'h1,'0}, '{ACC,8'h03,16'h100,17'h10800},
      '{ACC,8'h03,16'hFF,17'h131}, '{ACC,8'h10,16'h105,17'h10805}, '{ACC,8'h06,16'h102,17'h10802},
      '{ACC,8'h04,16'h105,17'h137}, '{WR,8'hB7,16'h2,'0}, '{RXC,8'h0,16'h0A5,17'h0},
      '{RXC,8'h0,16'h1A5,17'h1}, '{WR,8'hB7,16'h1,'0}, '{RXC,8'h0,16'h0A5,17'h1},
      '{WR,8'hB8,16'h5,'0}, '{RXC,8'h0,16'h1F,17'h0}, '{RXC,8'h0,16'h3F,17'h1},
      '{WR,8'hB7,16'h2,'0}, '{WR,8'hB8,16'h8,'0}, '{WR,8'hB9,16'h2,'0},
      '{WR,8'hBD,16'h1,'0}, '{WR,8'hB1,16'h1,'0}};
   const msp_row_s slow [6] = '{'{WR,8'hB9,16'h1,'0}, '{WR,8'hB7,16'h0,'0},
      '{WR,8'hBD,16'h0,'0}, '{WR,8'hBA,16'h1,'0}, '{WR,8'hBB,16'h1,'0}, '{WR,8'hBC,16'h1,'0}};

   msp_port i_msp_port (.ref_clk, .reset, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_wdata, .cfg_rdata,
      .cfg_rvalid, .acc_valid, .acc_func, .acc_reg, .acc_hold_base, .acc_map, .acc_map_valid,
      .tx_valid, .tx_data, .tx_last, .tx_ready, .rx_hdr_valid, .rx_hdr_addr, .req_accept,
      .req_drop, .rx_char_valid, .rx_char, .rx_parity_err, .baud_tick, .cts, .txd, .rts,
      .port_active, .role, .ascii_mode);
   msp_remote i_msp_remote (.ref_clk, .reset, .baud_tick, .txd, .rts, .cts, .cts_hold, .nbits,
      .got_char, .got_valid, .last_gap);

   always #20 ref_clk = ~ref_clk;
   // bit time of four clocks keeps frames short
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      tick_cnt <= tick_cnt + 2'h1;
      baud_tick <= (tick_cnt == 2'h3);
   end

   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic stop_test;
      $display("compared %0d, mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic ran_out;
      err_total++;
      $display("CHECK FAILED at %0t: wait ran out", $time);
      stop_test();
   endtask
   // one strobe, then up to three cycles to catch the registered answer
   task automatic apply(input msp_row_s r);
      logic [16:0] seen;
      seen = (r.op == RD || r.op == ACC) ? '1 : '0;
      cfg_addr <= {8'h13, r.a};
      cfg_wdata <= r.b;
      acc_func <= r.a;
      acc_reg <= r.b;
      rx_hdr_addr <= r.a;
      rx_char <= r.b[8:0];
      cfg_wr <= (r.op == WR);
      cfg_rd <= (r.op == RD);
      acc_valid <= (r.op == ACC);
      rx_hdr_valid <= (r.op == HDR);
      rx_char_valid <= (r.op == RXC);
      @(posedge ref_clk);
      {cfg_wr, cfg_rd, acc_valid, rx_hdr_valid, rx_char_valid} <= 5'h0;
      repeat (3) begin
         #1;
         if (r.op == RD && cfg_rvalid === 1'b1) seen = {1'b0, cfg_rdata};
         if (r.op == ACC && acc_map_valid === 1'b1) seen = acc_map;
         if (r.op == HDR) seen = seen | {req_accept, req_drop};
         if (r.op == RXC) seen = seen | rx_parity_err;
         @(posedge ref_clk);
      end
      if (r.op == STS) seen = {port_active, role, ascii_mode};
      if (r.op != WR) check(seen, r.e);
   endtask
   task automatic wait_on(input int which, input logic lvl, output int t);
      logic s;
      for (int i = 0; i < 40000; i++) begin
         @(posedge ref_clk);
         s = (which == 0) ? rts : (which == 1) ? txd : got_valid;
         if (s === lvl) begin
            t = cyc;
            return;
         end
      end
      ran_out();
   endtask
   // holds the byte until tx_ready is seen at an edge
   task automatic push(input logic [7:0] d, input logic last, output int t);
      tx_valid <= 1'b1;
      tx_data <= d;
      tx_last <= last;
      for (int i = 0; i < 40000; i++) begin
         @(posedge ref_clk);
         if (tx_ready === 1'b1) begin
            t = cyc;
            if (last) tx_valid <= 1'b0;
            return;
         end
      end
      ran_out();
   endtask

   initial begin
      int t0, t1, t2;
      logic quiet;
      repeat (16) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (3) @(posedge ref_clk);
      #1;
      check(17'({port_active, tx_ready, txd, rts}), 17'h2);
      @(posedge ref_clk);
      for (int i = 0; i < 50; i++) apply(rows[i]);
      cts_hold <= 1'b1;
      push(8'hA5, 1'b0, t0);
      push(8'h3D, 1'b1, t0);
      wait_on(0, 1'b1, t1);
      quiet = 1'b1;
      repeat (200) begin
         @(posedge ref_clk);
         if (txd !== 1'b1) quiet = 1'b0;
      end
      check(17'(quiet), 17'h1);
      cts_hold <= 1'b0;
      wait_on(2, 1'b1, t1);
      check(17'(got_char), 17'h0A5);
      wait_on(2, 1'b1, t1);
      check(17'(got_char), 17'h13D);
      check(17'(last_gap), 17'h2);
      wait_on(0, 1'b0, t1);
      for (int i = 0; i < 6; i++) apply(slow[i]);
      nbits <= 4'h8;
      cts_hold <= 1'b1;
      push(8'h55, 1'b0, t0);
      push(8'h0F, 1'b1, t1);
      wait_on(0, 1'b1, t1);
      check(17'(t1 - t0 >= 25000 && t1 - t0 <= 25010), 17'h1);
      wait_on(1, 1'b0, t2);
      check(17'(t2 - t1 >= 25000 && t2 - t1 <= 25010), 17'h1);
      wait_on(2, 1'b1, t1);
      check(17'(got_char), 17'h055);
      wait_on(2, 1'b1, t1);
      check(17'(got_char), 17'h00F);
      check(17'(last_gap), 17'h1);
      wait_on(0, 1'b0, t2);
      check(17'(t2 - t1 >= 25000 && t2 - t1 <= 25012), 17'h1);
      // second reset in mid-run returns the defaults
      reset <= 1'b1;
      repeat (2) @(posedge ref_clk);
      check(17'({txd, rts}), 17'h2);
      reset <= 1'b0;
      @(posedge ref_clk);
      apply(msp_row_s'{RD,8'hB0,'0,17'h0});
      apply(msp_row_s'{RD,8'hBC,'0,17'h0});
      stop_test();
   end
endmodule // msp_port_tb
`default_nettype wire
